//--- verilog/rcsm_pkg.sv
// Purpose: Constants for the reset combiner and supply monitor
// Assumes: Core clock of 50 MHz
// Notes:   Cycle counts derive from times in ns
package rcsm_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Core supply must stay low this long before power-on reset
   localparam int POR_FILT_NS   = 90;
   localparam int POR_FILT_CYC  = (POR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Latest assertion after detection
   localparam int POR_MAX_NS    = 1500;
   localparam int POR_MAX_CYC   = POR_MAX_NS / CLK_PERIOD_NS;
   // Least power-on reset pulse
   localparam int POR_HOLD_NS   = 361;
   localparam int POR_HOLD_CYC  = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Under-voltage anti-glitch filter, typical and limits
   localparam int UV_FILT_NS    = 1300;
   localparam int UV_FILT_CYC   = UV_FILT_NS / CLK_PERIOD_NS;
   localparam int UV_MIN_NS     = 800;
   localparam int UV_MIN_CYC    = (UV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UV_MAX_NS     = 2000;
   localparam int UV_MAX_CYC    = UV_MAX_NS / CLK_PERIOD_NS;
   localparam int CNT_W         = 8;
   localparam int BYTE_W        = 8;
   // Serial answers
   localparam logic [BYTE_W-1:0] CMD_PATTERN = 8'hA8;
   localparam logic [BYTE_W-1:0] RESET_READ  = 8'h00;
   // Synchroniser lanes
   localparam int SY_CORE_UV = 0;
   localparam int SY_LOGIC_UV = 1;
   localparam int SY_GATE_UV = 2;
   localparam int SY_OV = 3;
   localparam int SY_N = 4;
   typedef enum logic [0:0] {RCSM_POR_WATCH, RCSM_POR_ACTIVE} rcsm_por_e;
endpackage

//--- verilog/rcsm_top.sv
// Purpose: Core reset combiner and supply monitor logic
// Assumes: Comparator outputs and reset pin are asynchronous
// Notes:   Serial side and register file sit outside this block
//
// Behaviour
// - Core reset is AND of three sources
// - Power-on reset only after 90 ns low
// - Assert within 1.5 us, hold 361 ns
// - Serial port inactive during core reset
// - Command word returns 0xA8 outside reset
// - Reads return 0x00 during core reset
// - Either supply under-voltage disables pre-drivers
// - Logic supply under-voltage sets status bit
// - Enabled logic under-voltage raises interrupt immediately
// - Logic under-voltage through 1.3 us filter
// - Over-voltage disables gate regulator until normal
// - Gate under-voltage off, filtered re-enable
// - Interrupts on active-low request pin
`timescale 1ns/10ps
module rcsm_top #(
   parameter int UV_FILT = rcsm_pkg::UV_FILT_CYC
) (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   // Asynchronous comparators and pin
   input  wire logic                       core_supply_2v5_uvlo,
   input  wire logic                       logic_supply_undervolt,
   input  wire logic                       gate_supply_undervolt,
   input  wire logic                       main_5v_supply_overvolt,
   input  wire logic                       external_reset_n,
   // Serial interface side, same clock
   input  wire logic                       serial_requested_reset_n,
   input  wire logic                       command_word_phase,
   input  wire logic [rcsm_pkg::BYTE_W-1:0] register_read_data,
   // Software controls, same clock
   input  wire logic                       status_clear,
   input  wire logic                       logic_uv_irq_en,
   input  wire logic                       gate_uv_irq_en,
   // Resets out
   output logic                            power_on_reset_n,
   output logic                            core_reset_n,
   // Serial answers
   output logic                            serial_active,
   output logic [rcsm_pkg::BYTE_W-1:0]     serial_return_data,
   // Supply control and status
   output logic                            predriver_enable,
   output logic                            gate_regulator_enable,
   output logic                            logic_uv_status,
   output logic                            gate_uv_status,
   output logic                            interrupt_request_n
);
   import rcsm_pkg::*;

   // Filter must fit the counter and the allowed window
   if (UV_FILT < UV_MIN_CYC || UV_FILT > UV_MAX_CYC || UV_FILT >= (1 << CNT_W)) begin : g_chk
      $error("UV_FILT outside the allowed filter window");
   end
   localparam logic [CNT_W-1:0] UV_LAST  = CNT_W'(UV_FILT - 1);
   localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_FILT_CYC - 1);
   localparam logic [CNT_W-1:0] HLD_LAST = CNT_W'(POR_HOLD_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

   logic [SY_N-1:0]   sync_meta;
   logic [SY_N-1:0]   sync_q;
   logic              core_uv;
   logic              logic_uv;
   logic              gate_uv;
   logic              ov;
   rcsm_por_e         por_state;
   rcsm_por_e         next_por_state;
   logic [CNT_W-1:0]  por_cnt;
   logic [CNT_W-1:0]  next_por_cnt;
   logic              raw_reset_n;
   logic              rst_meta;
   logic              core_rst;
   logic              lu_filt;
   logic [CNT_W-1:0]  lu_cnt;
   logic              gu_filt;
   logic [CNT_W-1:0]  gu_cnt;
   logic              lu_filt_q;
   logic              gu_filt_q;
   logic              lu_rise;
   logic              gu_rise;
   logic              next_logic_uv_status;
   logic              next_gate_uv_status;
   logic              irq_cause;
   logic [BYTE_W-1:0] next_serial_return_data;

   // Two-stage synchronisers; only stage two is read
   always_ff @(posedge clock) begin
      sync_meta <= {main_5v_supply_overvolt, gate_supply_undervolt,
                    logic_supply_undervolt, core_supply_2v5_uvlo};
      sync_q    <= sync_meta;
   end

   assign core_uv  = sync_q[SY_CORE_UV];
   assign logic_uv = sync_q[SY_LOGIC_UV];
   assign gate_uv  = sync_q[SY_GATE_UV];
   assign ov       = sync_q[SY_OV];

   // Power-on reset sequencer; glitches shorter than the filter vanish
   always_comb begin
      next_por_state = por_state;
      next_por_cnt   = por_cnt + CNT_ONE;
      case (por_state)
         RCSM_POR_WATCH: begin
            if (!core_uv) begin
               next_por_cnt = CNT_ZERO;
            end else if (por_cnt >= POR_LAST) begin
               next_por_state = RCSM_POR_ACTIVE;
               next_por_cnt   = CNT_ZERO;
            end
         end
         RCSM_POR_ACTIVE: begin
            if (por_cnt >= HLD_LAST) begin
               next_por_cnt = por_cnt;  // Saturate while supply stays low
               if (!core_uv) begin
                  next_por_state = RCSM_POR_WATCH;
                  next_por_cnt   = CNT_ZERO;
               end
            end
         end
         default: begin
            next_por_state = RCSM_POR_ACTIVE;
            next_por_cnt   = CNT_ZERO;
         end
      endcase
   end

   // Reset starts in power-on reset so the core wakes clean
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         por_state        <= RCSM_POR_ACTIVE;
         por_cnt          <= CNT_ZERO;
         power_on_reset_n <= 1'b0;
      end else begin
         por_state        <= next_por_state;
         por_cnt          <= next_por_cnt;
         power_on_reset_n <= (next_por_state == RCSM_POR_WATCH);
      end
   end

   // Combined source; pin is used raw only to assert at once
   assign raw_reset_n = power_on_reset_n & external_reset_n
                        & serial_requested_reset_n;

   // Async assert, release after two clean edges
   always_ff @(posedge clock or negedge raw_reset_n) begin
      if (!raw_reset_n) begin
         rst_meta      <= 1'b0;
         core_reset_n  <= 1'b0;
         serial_active <= 1'b0;
      end else if (sys_rst) begin
         rst_meta      <= 1'b0;
         core_reset_n  <= 1'b0;
         serial_active <= 1'b0;
      end else begin
         rst_meta      <= 1'b1;
         core_reset_n  <= rst_meta;
         serial_active <= core_reset_n;
      end
   end

   assign core_rst = sys_rst | ~core_reset_n;

   // Serial answer; zero in reset so host sees no pattern
   assign next_serial_return_data = !core_reset_n      ? RESET_READ :
                                    command_word_phase ? CMD_PATTERN :
                                    register_read_data;

   always_ff @(posedge clock or negedge raw_reset_n) begin
      if (!raw_reset_n) begin
         serial_return_data <= RESET_READ;
      end else begin
         serial_return_data <= next_serial_return_data;
      end
   end

   // Symmetric anti-glitch filter on logic supply under-voltage
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lu_filt <= 1'b1;
         lu_cnt  <= CNT_ZERO;
      end else if (logic_uv == lu_filt) begin
         lu_cnt  <= CNT_ZERO;
      end else if (lu_cnt >= UV_LAST) begin
         lu_filt <= logic_uv;
         lu_cnt  <= CNT_ZERO;
      end else begin
         lu_cnt  <= lu_cnt + CNT_ONE;
      end
   end

   // Gate supply: drop at once, recover only after the filter
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gu_filt <= 1'b1;
         gu_cnt  <= CNT_ZERO;
      end else if (gate_uv) begin
         gu_filt <= 1'b1;
         gu_cnt  <= CNT_ZERO;
      end else if (gu_filt && gu_cnt >= UV_LAST) begin
         gu_filt <= 1'b0;
         gu_cnt  <= CNT_ZERO;
      end else if (gu_filt) begin
         gu_cnt  <= gu_cnt + CNT_ONE;
      end
   end

   // Sticky status; a new event beats a clear in the same cycle
   assign lu_rise = lu_filt & ~lu_filt_q;
   assign gu_rise = gu_filt & ~gu_filt_q;
   assign next_logic_uv_status = lu_rise | (logic_uv_status & ~status_clear);
   assign next_gate_uv_status  = gu_rise | (gate_uv_status & ~status_clear);
   assign irq_cause = (next_logic_uv_status & logic_uv_irq_en)
                      | (next_gate_uv_status & gate_uv_irq_en);

   always_ff @(posedge clock) begin
      if (core_rst) begin
         lu_filt_q           <= 1'b1;
         gu_filt_q           <= 1'b1;
         logic_uv_status     <= 1'b0;
         gate_uv_status      <= 1'b0;
         interrupt_request_n <= 1'b1;
      end else begin
         lu_filt_q           <= lu_filt;
         gu_filt_q           <= gu_filt;
         logic_uv_status     <= next_logic_uv_status;
         gate_uv_status      <= next_gate_uv_status;
         interrupt_request_n <= ~irq_cause;
      end
   end

   // Supply-driven enables; everything off while the core is in reset
   always_ff @(posedge clock) begin
      if (core_rst) begin
         predriver_enable      <= 1'b0;
         gate_regulator_enable <= 1'b0;
      end else begin
         predriver_enable      <= ~(lu_filt | gu_filt);
         gate_regulator_enable <= ~ov;
      end
   end

   // Checks
   localparam int A_POR_MAX = POR_MAX_CYC;
   logic [CNT_W-1:0] a_low_cnt;
   // Helper: cycles power-on reset has been low
   always_ff @(posedge clock) begin
      if (sys_rst || power_on_reset_n) begin
         a_low_cnt <= CNT_ZERO;
      end else if (a_low_cnt != {CNT_W{1'b1}}) begin
         a_low_cnt <= a_low_cnt + CNT_ONE;
      end
   end

   property p_core_and;
      @(posedge clock) disable iff (sys_rst)
         (!power_on_reset_n || !serial_requested_reset_n) |-> !core_reset_n;
   endproperty
   a_core_and: assert property (p_core_and) else $error("core reset not combined");

   property p_por_filter;
      @(posedge clock) disable iff (sys_rst)
         $fell(power_on_reset_n) |-> $past(core_uv) && $past(core_uv, POR_FILT_CYC);
   endproperty
   a_por_filter: assert property (p_por_filter) else $error("por without 90 ns low");

   property p_por_latest;
      @(posedge clock) disable iff (sys_rst)
         $rose(core_uv) |-> ##[0:A_POR_MAX] (!power_on_reset_n || !core_uv);
   endproperty
   a_por_latest: assert property (p_por_latest) else $error("por asserted too late");

   property p_por_hold;
      @(posedge clock) disable iff (sys_rst)
         $rose(power_on_reset_n) |-> $past(a_low_cnt) >= CNT_W'(POR_HOLD_CYC - 1);
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("por pulse too short");

   property p_serial_quiet;
      @(posedge clock) disable iff (sys_rst)
         !core_reset_n |-> !serial_active && serial_return_data == RESET_READ;
   endproperty
   a_serial_quiet: assert property (p_serial_quiet) else $error("serial live in reset");

   property p_pattern;
      @(posedge clock) disable iff (sys_rst)
         core_reset_n && command_word_phase |=> !core_reset_n || serial_return_data == CMD_PATTERN;
   endproperty
   a_pattern: assert property (p_pattern) else $error("command pattern wrong");

   property p_predrv_off;
      @(posedge clock) disable iff (sys_rst)
         (lu_filt || gu_filt) |=> !predriver_enable;
   endproperty
   a_predrv_off: assert property (p_predrv_off) else $error("pre-drivers on in uv");

   property p_status_set;
      @(posedge clock) disable iff (core_rst)
         $rose(lu_filt) |=> logic_uv_status;
   endproperty
   a_status_set: assert property (p_status_set) else $error("status not set");

   property p_irq;
      @(posedge clock) disable iff (core_rst)
         $rose(lu_filt) && logic_uv_irq_en |=> !interrupt_request_n;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_glitch;
      @(posedge clock) disable iff (sys_rst)
         $rose(logic_uv) && !lu_filt |-> !lu_filt[*8];
   endproperty
   a_glitch: assert property (p_glitch) else $error("uv filter too fast");

   property p_ov;
      @(posedge clock) disable iff (sys_rst)
         core_reset_n ##0 ov |=> !gate_regulator_enable;
   endproperty
   a_ov: assert property (p_ov) else $error("regulator on in over-voltage");

   property p_gate_off;
      @(posedge clock) disable iff (sys_rst)
         gate_uv |=> gu_filt ##1 !predriver_enable;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate uv not acted on");

   property p_sticky;
      @(posedge clock) disable iff (core_rst)
         logic_uv_status && !status_clear |=> logic_uv_status;
   endproperty
   a_sticky: assert property (p_sticky) else $error("status lost");
endmodule // rcsm_top

//--- dv/rcsm_host_model.sv
// Purpose: Host side model, serial framing and reset lines
// Assumes: Same clock as the core, changes just after rising edges
// Notes:   Message is one command slot then three data slots
`timescale 1ns/10ps
module rcsm_host_model (
   // Clock and controls from the bench
   input  wire logic clock,
   input  wire logic run,
   input  wire logic req_reset,
   input  wire logic pin_reset,
   // Lines towards the core
   output logic      command_word_phase,
   output logic      serial_requested_reset_n,
   output logic      external_reset_n
);
   logic [1:0] slot;

   initial begin
      slot                     = 2'h0;
      command_word_phase       = 1'b0;
      serial_requested_reset_n = 1'b1;
      external_reset_n         = 1'b1;
   end

   // Back-to-back messages; the command slot lets the host spot reset
   always @(posedge clock) begin
      slot                     <= run ? slot + 2'h1 : 2'h0;
      command_word_phase       <= run && (slot == 2'h0);
      serial_requested_reset_n <= ~req_reset;
      external_reset_n         <= ~pin_reset;
   end
endmodule // rcsm_host_model

//--- dv/reset_combine_supply_monitor_bench.sv
// Purpose: Self-checking bench for the reset combiner and supply monitor
// Assumes: Filter shortened to 40 cycles, 50 MHz clock
// Notes:   Serial bytes checked against a queue model each cycle of the serial test, except across reset edges
`timescale 1ns/10ps
module reset_combine_supply_monitor_bench;
   import rcsm_pkg::*;
   localparam int FILT = 40;
   logic       clock = 1'b0, sys_rst = 1'b1, uvlo = 1'b0, luv = 1'b0, guv = 1'b0;
   logic       ov = 1'b0, run = 1'b0, req_reset = 1'b0, pin_reset = 1'b0, mon = 1'b0;
   logic       clr = 1'b0, len = 1'b0, gen = 1'b0, prev_mdl = 1'b0, mdl;
   logic [2:0] raw_hist = 3'h0;
   logic       phase, srq_n, ext_n, por_n, core_n, sact, pre, greg, lst, gst, irq_n;
   logic [7:0] rdata = 8'h00, sdata, e;
   logic [7:0] exp_q[$];
   int         n_fail = 0, compares = 0, cyc = 0, n;
   wire  [7:0] obs = {gst, irq_n, lst, greg, pre, sact, core_n, por_n};

   always #10 clock = ~clock;

   rcsm_host_model host (.clock(clock), .run(run), .req_reset(req_reset),
      .pin_reset(pin_reset), .command_word_phase(phase),
      .serial_requested_reset_n(srq_n), .external_reset_n(ext_n));

   rcsm_top #(.UV_FILT(FILT)) dut (.clock(clock), .sys_rst(sys_rst),
      .core_supply_2v5_uvlo(uvlo), .logic_supply_undervolt(luv),
      .gate_supply_undervolt(guv), .main_5v_supply_overvolt(ov),
      .external_reset_n(ext_n), .serial_requested_reset_n(srq_n),
      .command_word_phase(phase), .register_read_data(rdata), .status_clear(clr),
      .logic_uv_irq_en(len), .gate_uv_irq_en(gen), .power_on_reset_n(por_n),
      .core_reset_n(core_n), .serial_active(sact), .serial_return_data(sdata),
      .predriver_enable(pre), .gate_regulator_enable(greg), .logic_uv_status(lst),
      .gate_uv_status(gst), .interrupt_request_n(irq_n));

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Bounded wait on one observed output, cycles spent returned in cnt
   task automatic wt(input int i, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (obs[i] !== v && cnt < lim) begin
         @(posedge clock);
         cnt++;
      end
      chk("wait reached", {7'h0, obs[i]}, {7'h0, v});
   endtask

   task automatic print_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Queue model of the serial answer; core reset modelled from the host lines,
   // released after three clean samples, and skipped across reset edges
   always @(posedge clock) begin
      raw_hist = {raw_hist[1:0], srq_n & ext_n};
      mdl      = &raw_hist;
      if (mon) chk("core_reset_n model", {7'h0, core_n}, {7'h0, mdl});
      if (mon && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (prev_mdl === mdl) chk("serial_return_data", sdata, e);
      end
      if (mon) exp_q.push_back(mdl ? (phase ? CMD_PATTERN : rdata) : RESET_READ);
      prev_mdl = mdl;
   end

   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(32'hB7013583));
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      wt(1, 1'b1, 100, n);
      wt(2, 1'b1, 5, n);
      wt(3, 1'b1, 100, n);
      $display("test reset release done");
      // Serial traffic, then serial request and pin reset in mid-run
      run <= 1'b1;
      mon <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 60; k++) begin
            @(posedge clock);
            rdata <= ($urandom % 2) ? 8'hFF : 8'($urandom);
            if (k == 20) begin
               if (s == 0) req_reset <= 1'b1;
               else pin_reset <= 1'b1;
            end
            if (k == 24) chk("core_reset_n", {7'h0, core_n}, 8'h00);
            if (k == 24) chk("serial_active", {7'h0, sact}, 8'h00);
            if (k == 30) {req_reset, pin_reset} <= 2'b00;
         end
      end
      mon <= 1'b0;
      $display("test serial done");
      // Short core supply glitch, then a real dip
      uvlo <= 1'b1;
      repeat (3) @(posedge clock);
      uvlo <= 1'b0;
      repeat (10) @(posedge clock);
      chk("power_on_reset_n", {7'h0, por_n}, 8'h01);
      uvlo <= 1'b1;
      wt(0, 1'b0, POR_MAX_CYC, n);
      chk("core after por", {7'h0, core_n}, 8'h00);
      uvlo <= 1'b0;
      wt(0, 1'b1, 100, n);
      chk("por held", {7'h0, 1'(n >= POR_HOLD_CYC)}, 8'h01);
      wt(2, 1'b1, 10, n);
      $display("test power-on reset done");
      // Logic supply dip with interrupt off then on
      for (int en = 0; en < 2; en++) begin
         len <= 1'(en);
         luv <= 1'b1;
         wt(5, 1'b1, 80, n);
         chk("uv filter", {7'h0, 1'(n >= FILT && n <= FILT + 4)}, 8'h01);
         repeat (2) @(posedge clock);
         chk("interrupt_request_n", {7'h0, irq_n}, {7'h0, 1'(en == 0)});
         chk("predriver_enable", {7'h0, pre}, 8'h00);
         clr <= 1'b1;
         @(posedge clock);
         clr <= 1'b0;
         repeat (5) @(posedge clock);
         chk("status cleared", {7'h0, lst}, 8'h00);
         chk("irq released", {7'h0, irq_n}, 8'h01);
         luv <= 1'b0;
         wt(3, 1'b1, 80, n);
      end
      // Glitch shorter than the filter leaves no trace
      luv <= 1'b1;
      repeat (10) @(posedge clock);
      luv <= 1'b0;
      repeat (60) @(posedge clock);
      chk("glitch status", {7'h0, lst}, 8'h00);
      $display("test logic supply done");
      // Gate supply dip: quick off, filtered on
      gen <= 1'b1;
      guv <= 1'b1;
      wt(3, 1'b0, 6, n);
      chk("gate_uv_status", {7'h0, gst}, 8'h01);
      chk("gate interrupt", {7'h0, irq_n}, 8'h00);
      guv <= 1'b0;
      wt(3, 1'b1, 80, n);
      chk("gate recovery", {7'h0, 1'(n >= FILT && n <= FILT + 4)}, 8'h01);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      @(posedge clock);
      chk("gate status cleared", {7'h0, gst}, 8'h00);
      chk("gate irq released", {7'h0, irq_n}, 8'h01);
      // Over-voltage turns the gate regulator off and back on
      ov <= 1'b1;
      wt(4, 1'b0, 6, n);
      ov <= 1'b0;
      wt(4, 1'b1, 6, n);
      $display("test gate supply and over-voltage done");
      print_verdict();
   end
endmodule // reset_combine_supply_monitor_bench
